// >>> rtl/umc_modem_ctrl.sv
// modem control and modem status logic of a uart, with apb registers,
// loopback steering of the serial path and the interrupt identification.
// assumes modem pins already meet clk_i timing apart from metastability,
// and line error events arrive as one-cycle pulses from the receiver.
//
// Function
// - control bits 0-3 drive outputs inverted
// - modem control register readable and writable
// - control bits 5-7 always read zero
// - loopback holds serial out marking, ignores input
// - loopback feeds transmitter output into receiver
// - loopback replaces modem inputs with control bits
// - loopback maps rts-cts, dtr-dsr, user_output_one-ri, user_output_two-dcd
// - loopback drives all modem outputs high
// - loopback interrupts work, modem source from control
// - status layout: four flags, then four states
// - state bits are inverted pin levels
// - cts, dsr, dcd change sets flag
// - ring flag only on pin rising
// - status read clears flags, keeps states
// - state bits track pins regardless of masks
// - change during read: lost if set
// - no flag setting during status read
// - set flag recurring in read clears
// - modem change gives priority four interrupt
`timescale 1ns/100ps
module umc_modem_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [umc_pkg::UMC_ADDR_W-1:0] paddr_i,
    input wire logic [umc_pkg::UMC_DATA_W-1:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [umc_pkg::UMC_DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // modem pins, active low
    input wire umc_pkg::umc_modem_in_t modem_in_n_i,
    output umc_pkg::umc_modem_out_t modem_out_n_o,
    // serial path
    input wire logic tx_shift_out_i,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic rx_shift_in_o,
    // receiver and transmitter status
    input wire umc_pkg::umc_line_err_t line_err_pulse_i,
    input wire logic data_ready_i,
    input wire logic thr_empty_i,
    input wire logic tx_empty_i,
    input wire logic rda_request_i,
    input wire logic thre_request_i,
    // interrupt
    output logic interrupt_request_out_o
);
    import umc_pkg::*;

    // sticky flag update shared by both status registers: while a read of
    // the register runs nothing is set, events are held and resolved at the
    // read's end, where a flag already shown to software drops instead
    function automatic logic [3:0] umc_flag_next(
        input logic [3:0] flag,
        input logic [3:0] hold,
        input logic [3:0] ev,
        input logic busy,
        input logic done
    );
        logic [3:0] res;
        res = flag | ev;
        if (done) begin
            res = ~flag & (hold | ev);
        end else if (busy) begin
            res = flag;
        end
        return res;
    endfunction : umc_flag_next

    function automatic logic [3:0] umc_hold_next(
        input logic [3:0] hold,
        input logic [3:0] ev,
        input logic busy,
        input logic done
    );
        logic [3:0] res;
        res = 4'h0;
        if (busy && !done) begin
            res = hold | ev;
        end
        return res;
    endfunction : umc_hold_next

    logic [UMC_MC_W-1:0] modem_control_reg;
    logic [3:0] int_enables_reg;
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic [3:0] state_prev_reg;
    logic [3:0] modem_flag_reg;
    logic [3:0] modem_hold_reg;
    logic [3:0] line_flag_reg;
    logic [3:0] line_hold_reg;
    logic [UMC_DATA_W-1:0] rdata_reg;
    logic interrupt_reg;
    logic [3:0] modem_out_n_reg;
    logic serial_out_reg;
    logic rx_in_reg;

    logic loop_on;
    logic addr_hit;
    logic setup_ph;
    logic access_ph;
    logic wr_ctl;
    logic wr_ie;
    logic msr_busy;
    logic msr_done;
    logic lsr_busy;
    logic lsr_done;
    logic [3:0] state_now;
    logic [3:0] modem_ev;
    logic [7:0] modem_status;
    logic [7:0] line_status;
    logic [7:0] int_ident;
    logic [UMC_DATA_W-1:0] rdata_next;

    assign loop_on = modem_control_reg[UMC_MC_LOOP];
    assign setup_ph = psel_i && !penable_i;
    assign access_ph = psel_i && penable_i;

    assign addr_hit = (paddr_i == UMC_OFF_MODEM_CONTROL) ||
                      (paddr_i == UMC_OFF_MODEM_STATUS) ||
                      (paddr_i == UMC_OFF_LINE_STATUS) ||
                      (paddr_i == UMC_OFF_INT_ENABLES) ||
                      (paddr_i == UMC_OFF_INT_IDENT);

    // slave always ready: every access phase completes in one cycle
    assign pready_o = 1'b1;
    assign pslverr_o = access_ph && !addr_hit;
    assign prdata_o = rdata_reg;

    assign wr_ctl = access_ph && pwrite_i && pstrb_i[0] &&
                    (paddr_i == UMC_OFF_MODEM_CONTROL);
    assign wr_ie = access_ph && pwrite_i && pstrb_i[0] &&
                   (paddr_i == UMC_OFF_INT_ENABLES);

    assign msr_busy = psel_i && !pwrite_i && (paddr_i == UMC_OFF_MODEM_STATUS);
    assign msr_done = msr_busy && penable_i;
    assign lsr_busy = psel_i && !pwrite_i && (paddr_i == UMC_OFF_LINE_STATUS);
    assign lsr_done = lsr_busy && penable_i;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            modem_control_reg <= UMC_MC_RESET;
        end else if (wr_ctl) begin
            modem_control_reg <= pwdata_i[UMC_MC_W-1:0];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            int_enables_reg <= UMC_IE_RESET;
        end else if (wr_ie) begin
            int_enables_reg <= pwdata_i[3:0];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_meta_reg <= UMC_PIN_IDLE;
            pin_sync_reg <= UMC_PIN_IDLE;
        end else begin
            pin_meta_reg <= modem_in_n_i;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // state order is cts, dsr, ri, dcd in bits 0..3
    always_comb begin
        state_now = ~pin_sync_reg;
        if (loop_on) begin
            state_now[0] = modem_control_reg[UMC_MC_RTS];
            state_now[1] = modem_control_reg[UMC_MC_DTR];
            state_now[2] = modem_control_reg[UMC_MC_USER_OUTPUT_ONE];
            state_now[3] = modem_control_reg[UMC_MC_USER_OUTPUT_TWO];
        end
    end

    // any change on cts, dsr, dcd
    assign modem_ev[0] = state_now[0] ^ state_prev_reg[0];
    assign modem_ev[1] = state_now[1] ^ state_prev_reg[1];
    assign modem_ev[3] = state_now[3] ^ state_prev_reg[3];
    // ring pin rising is state falling
    assign modem_ev[2] = state_prev_reg[2] && !state_now[2];

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_prev_reg <= 4'h0;
        end else begin
            state_prev_reg <= state_now;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            modem_flag_reg <= 4'h0;
            modem_hold_reg <= 4'h0;
        end else begin
            modem_flag_reg <= umc_flag_next(modem_flag_reg, modem_hold_reg, modem_ev,
                                            msr_busy, msr_done);
            modem_hold_reg <= umc_hold_next(modem_hold_reg, modem_ev, msr_busy, msr_done);
        end
    end

    // line error flags, same read discipline
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            line_flag_reg <= 4'h0;
            line_hold_reg <= 4'h0;
        end else begin
            line_flag_reg <= umc_flag_next(line_flag_reg, line_hold_reg, line_err_pulse_i,
                                           lsr_busy, lsr_done);
            line_hold_reg <= umc_hold_next(line_hold_reg, line_err_pulse_i, lsr_busy,
                                           lsr_done);
        end
    end

    assign modem_status = {state_now, modem_flag_reg};
    assign line_status = {1'b0, tx_empty_i, thr_empty_i, line_flag_reg, data_ready_i};

    always_comb begin
        int_ident = UMC_II_NONE;
        if (int_enables_reg[UMC_IE_RLS] && (|line_flag_reg)) begin
            int_ident = UMC_II_RLS;
        end else if (int_enables_reg[UMC_IE_RDA] && rda_request_i) begin
            int_ident = UMC_II_RDA;
        end else if (int_enables_reg[UMC_IE_THRE] && thre_request_i) begin
            int_ident = UMC_II_THRE;
        end else if (int_enables_reg[UMC_IE_MODEM] && (|modem_flag_reg)) begin
            int_ident = UMC_II_MODEM;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            interrupt_reg <= 1'b0;
        end else begin
            interrupt_reg <= !int_ident[0];
        end
    end
    assign interrupt_request_out_o = interrupt_reg;

    // read data is captured in the setup cycle so the value returned is the
    // one the flag logic later clears
    always_comb begin
        rdata_next = '0;
        case (paddr_i)
            UMC_OFF_MODEM_CONTROL: rdata_next[UMC_MC_W-1:0] = modem_control_reg;
            UMC_OFF_MODEM_STATUS: rdata_next[7:0] = modem_status;
            UMC_OFF_LINE_STATUS: rdata_next[7:0] = line_status;
            UMC_OFF_INT_ENABLES: rdata_next[3:0] = int_enables_reg;
            UMC_OFF_INT_IDENT: rdata_next[7:0] = int_ident;
            default: rdata_next = '0;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_reg <= '0;
        end else if (setup_ph && !pwrite_i) begin
            rdata_reg <= rdata_next;
        end
    end

    // pin drivers registered; they follow a control write by one cycle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            modem_out_n_reg <= 4'hf;
        end else if (loop_on) begin
            modem_out_n_reg <= 4'hf;
        end else begin
            modem_out_n_reg <= ~modem_control_reg[3:0];
        end
    end
    assign modem_out_n_o = modem_out_n_reg;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            serial_out_reg <= 1'b1;
            rx_in_reg <= 1'b1;
        end else if (loop_on) begin
            serial_out_reg <= 1'b1;
            rx_in_reg <= tx_shift_out_i;
        end else begin
            serial_out_reg <= tx_shift_out_i;
            rx_in_reg <= serial_in_pin_i;
        end
    end
    assign serial_out_pin_o = serial_out_reg;
    assign rx_shift_in_o = rx_in_reg;

endmodule : umc_modem_ctrl

// >>> rtl/umc_pkg.sv
// package for the modem control and status block: register map, field
// positions, reset values and the structs that carry the modem lines.
// assumes a 32-bit apb master and a uart core that supplies the serial
// datapath, the line error pulses and the other two interrupt requests.
package umc_pkg;

    // apb geometry
    localparam int UMC_ADDR_W = 12;
    localparam int UMC_DATA_W = 32;

    // register byte offsets
    localparam logic [11:0] UMC_OFF_MODEM_CONTROL = 12'h000;
    localparam logic [11:0] UMC_OFF_MODEM_STATUS = 12'h004;
    localparam logic [11:0] UMC_OFF_LINE_STATUS = 12'h008;
    localparam logic [11:0] UMC_OFF_INT_ENABLES = 12'h00c;
    localparam logic [11:0] UMC_OFF_INT_IDENT = 12'h010;

    // modem control fields
    localparam int UMC_MC_DTR = 0;
    localparam int UMC_MC_RTS = 1;
    localparam int UMC_MC_USER_OUTPUT_ONE = 2;
    localparam int UMC_MC_USER_OUTPUT_TWO = 3;
    localparam int UMC_MC_LOOP = 4;
    localparam int UMC_MC_W = 5;
    localparam logic [4:0] UMC_MC_RESET = 5'h00;

    // interrupt enable fields
    localparam int UMC_IE_RDA = 0;
    localparam int UMC_IE_THRE = 1;
    localparam int UMC_IE_RLS = 2;
    localparam int UMC_IE_MODEM = 3;
    localparam logic [3:0] UMC_IE_RESET = 4'h0;

    // interrupt identification codes, bit 0 low means pending
    localparam logic [7:0] UMC_II_NONE = 8'h01;
    localparam logic [7:0] UMC_II_RLS = 8'h06;
    localparam logic [7:0] UMC_II_RDA = 8'h04;
    localparam logic [7:0] UMC_II_THRE = 8'h02;
    localparam logic [7:0] UMC_II_MODEM = 8'h00;

    // synchroniser reset level: pins idle high
    localparam logic [3:0] UMC_PIN_IDLE = 4'hf;

    // four modem inputs, order matches status bits 4..7
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } umc_modem_in_t;

    // four modem outputs, order matches control bits 0..3
    typedef struct packed {
        logic user_output_two;
        logic user_output_one;
        logic rts;
        logic dtr;
    } umc_modem_out_t;

    // flags raised by the receiver for the line status register
    typedef struct packed {
        logic brk;
        logic framing;
        logic parity;
        logic overrun;
    } umc_line_err_t;

endpackage : umc_pkg

// >>> testbench/tb_uart_modem_control_status.sv
// testbench: apb host, modem model and a read-data scoreboard
// assumes nothing of pready timing; every wait is bounded
`timescale 1ns/100ps
module tb_uart_modem_control_status;
    import umc_pkg::*;
    logic clk_i = 0, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_val, d;
    logic [3:0] pstrb = 4'h1, lag = 4'h0;
    logic pready, pslverr, serial_out_pin, rxi, irq, tx = 1, serial_in_pin = 1, dr = 0, te = 0, ring_n = 1, dcd_n = 1;
    umc_modem_in_t pins_n;
    umc_modem_out_t outs_n;
    logic [31:0] exp_q[$], msk_q[$];
    int errors = 0, samples_checked = 0, n;
    event rd_ev;
    umc_modem_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .modem_in_n_i(pins_n), .modem_out_n_o(outs_n), .tx_shift_out_i(tx),
        .serial_in_pin_i(serial_in_pin), .serial_out_pin_o(serial_out_pin), .rx_shift_in_o(rxi),
        .line_err_pulse_i(4'h0), .data_ready_i(dr), .thr_empty_i(te), .tx_empty_i(te),
        .rda_request_i(1'b0), .thre_request_i(1'b0), .interrupt_request_out_o(irq));
    umc_modem_model modem (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .modem_out_n_i(outs_n),
        .ring_n_i(ring_n), .dcd_n_i(dcd_n), .lag_i(lag), .modem_in_n_o(pins_n));
    initial forever #5 clk_i = ~clk_i;
    task automatic final_report();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] e, g, m);
        samples_checked++;
        if ((g & m) !== (e & m)) begin
            errors++;
            $display("FAIL %s exp %h got %h", nm, e & m, g & m);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, e, m);
        int k = 0;
        if (!w) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        @(posedge clk_i);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            errors++;
            final_report();
        end
        rd_val = prdata;
        // an unmapped offset must be refused with an error in its access phase
        if (a > 12'h010) chk("pslverr", 1, {31'h0, pslverr}, 1);
        if (a == 12'h000) chk("pslverr", 0, {31'h0, pslverr}, 1);
        if (!w) -> rd_ev;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1, a, wd, 0, 0);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, m);
        apb(0, a, 0, e, m);
    endtask : rd
    task automatic settle();
        repeat (20) @(posedge clk_i);
    endtask : settle
    // read results are judged in arrival order against the noted values
    initial forever begin
        @(rd_ev);
        chk("prdata", exp_q.pop_front(), rd_val, msk_q.pop_front());
    end
    always @(posedge clk_i) if (!sys_rst_i) begin
        tx <= 1'($urandom);
        serial_in_pin <= 1'($urandom);
        dr <= 1'($urandom);
        te <= 1'($urandom);
    end
    initial begin
        void'($urandom(94173));
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 0;
        rd(12'h000, 0, '1);
        settle();
        rd(12'h004, 0, 32'hff);
        lag <= 4'h9;
        repeat (4) begin
            d = $urandom & 32'hffffffef;
            wr(12'h000, d);
            rd(12'h000, {27'h0, d[4:0]}, '1);
            chk("pins", {28'h0, ~d[3:0]}, {28'h0, outs_n}, 32'hf);
        end
        pstrb <= 4'h0;
        wr(12'h000, 32'h1f);
        pstrb <= 4'h1;
        rd(12'h000, {27'h0, d[4:0]}, '1);
        rd(12'h040, 0, '1);
        lag <= 4'h0;
        wr(12'h000, 0);
        settle();
        rd(12'h004, 0, 0);
        rd(12'h004, 0, 32'hff);
        dcd_n <= 0;
        settle();
        rd(12'h004, 32'h88, 32'hff);
        rd(12'h004, 32'h80, 32'hff);
        wr(12'h000, 32'h2);
        settle();
        rd(12'h004, 32'h91, 32'hff);
        ring_n <= 0;
        settle();
        rd(12'h004, 32'hd0, 32'hff);
        ring_n <= 1;
        settle();
        rd(12'h004, 32'h94, 32'hff);
        dcd_n <= 1;
        settle();
        dcd_n <= 0;
        @(posedge clk_i);
        rd(12'h004, 0, 0);
        rd(12'h004, 0, 32'h8);
        dcd_n <= 1;
        @(posedge clk_i);
        rd(12'h004, 0, 0);
        settle();
        rd(12'h004, 32'h8, 32'h8);
        wr(12'h00c, 32'h8);
        wr(12'h000, 32'h15);
        n = 0;
        while (irq !== 1'b1 && n < 30) begin
            @(posedge clk_i);
            n++;
        end
        chk("irq", 1, {31'h0, irq}, 1);
        rd(12'h010, 32'h00, 32'hff);
        rd(12'h004, 32'h60, 32'hf0);
        dcd_n <= 0;
        ring_n <= 0;
        settle();
        rd(12'h004, 32'h60, 32'hff);
        rd(12'h010, 32'h01, 32'hff);
        wr(12'h000, 32'h1a);
        settle();
        rd(12'h004, 32'h9f, 32'hff);
        chk("pins", 32'hf, {28'h0, outs_n}, 32'hf);
        wr(12'h000, 0);
        settle();
        final_report();
    end
endmodule : tb_uart_modem_control_status

// >>> testbench/umc_modem_ctrl_props.sv
// checker for the modem control block, watching its ports only
// assumes tx and serial input are held high while reset is active
`timescale 1ns/100ps
module umc_modem_ctrl_props (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [umc_pkg::UMC_ADDR_W-1:0] paddr_i,
    input wire logic [umc_pkg::UMC_DATA_W-1:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [umc_pkg::UMC_DATA_W-1:0] prdata_o,
    input wire logic pslverr_o,
    // modem and serial
    input wire umc_pkg::umc_modem_in_t modem_in_n_i,
    input wire umc_pkg::umc_modem_out_t modem_out_n_o,
    input wire logic tx_shift_out_i,
    input wire logic serial_in_pin_i,
    input wire logic serial_out_pin_o,
    input wire logic rx_shift_in_o
);
    import umc_pkg::*;
    logic [4:0] ctl_q, ctl_d;
    logic [8:0] cnt, since_rd;
    logic acc, wr_c;
    assign acc = psel_i && penable_i && !pwrite_i;
    assign wr_c = psel_i && penable_i && pwrite_i && paddr_i == 12'h000 && pstrb_i[0];
    // mirror of the control register and its one-cycle-late copy
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctl_q <= UMC_MC_RESET;
            ctl_d <= UMC_MC_RESET;
        end else begin
            ctl_q <= wr_c ? pwdata_i[4:0] : ctl_q;
            ctl_d <= ctl_q;
        end
    end
    // quiet time of the status sources, and time since the last status read
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= 9'h000;
            since_rd <= 9'h000;
        end else begin
            cnt <= ($changed(modem_in_n_i) || wr_c) ? 9'h000 : cnt + {8'h00, cnt < 9'h0ff};
            since_rd <= (acc && paddr_i == 12'h004) ? 9'h000 : since_rd + {8'h00, since_rd < 9'h0ff};
        end
    end
    sequence msr_rd_s;
        acc && paddr_i == 12'h004 && cnt > 9'h005;
    endsequence
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    out_pin_a: assert property (modem_out_n_o == (ctl_d[4] ? 4'hf : ~ctl_d[3:0]))
        else $error("modem outputs do not follow control");
    ser_out_a: assert property (serial_out_pin_o == (ctl_d[4] || $past(tx_shift_out_i)))
        else $error("serial out wrong");
    rx_path_a: assert property (rx_shift_in_o == (ctl_d[4] ? $past(tx_shift_out_i) : $past(serial_in_pin_i)))
        else $error("receiver input wrong");
    ctrl_read_a: assert property (acc && paddr_i == 12'h000 |-> prdata_o == {27'h0, ctl_q})
        else $error("control read back wrong");
    state_pin_a: assert property (msr_rd_s ##0 !ctl_q[4] |-> prdata_o[7:4] == ~4'(modem_in_n_i))
        else $error("status states differ from pins");
    state_loop_a: assert property (msr_rd_s ##0 ctl_q[4] |-> prdata_o[7:4] == {ctl_q[3], ctl_q[2], ctl_q[0], ctl_q[1]})
        else $error("loop states differ from control");
    flag_clear_a: assert property (msr_rd_s ##0 cnt > since_rd + 9'h006 |-> prdata_o[3:0] == 4'h0)
        else $error("flags survive a read");
    unmapped_a: assert property (acc && paddr_i > 12'h010 |-> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access not refused");
endmodule : umc_modem_ctrl_props

bind umc_modem_ctrl umc_modem_ctrl_props props_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .modem_in_n_i(modem_in_n_i), .modem_out_n_o(modem_out_n_o),
    .tx_shift_out_i(tx_shift_out_i), .serial_in_pin_i(serial_in_pin_i),
    .serial_out_pin_o(serial_out_pin_o), .rx_shift_in_o(rx_shift_in_o));

// >>> testbench/umc_modem_model.sv
// far-side modem: echoes rts and dtr as cts and dsr after a lag
// ring and carrier levels come from the bench; lag below 16
`timescale 1ns/100ps
module umc_modem_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // terminal pins and bench controls
    input wire umc_pkg::umc_modem_out_t modem_out_n_i,
    input wire logic ring_n_i,
    input wire logic dcd_n_i,
    input wire logic [3:0] lag_i,
    // modem pins, active low
    output umc_pkg::umc_modem_in_t modem_in_n_o
);
    import umc_pkg::*;
    logic [15:0] rts_hist_reg, dtr_hist_reg;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rts_hist_reg <= 16'hffff;
            dtr_hist_reg <= 16'hffff;
        end else begin
            rts_hist_reg <= {rts_hist_reg[14:0], modem_out_n_i.rts};
            dtr_hist_reg <= {dtr_hist_reg[14:0], modem_out_n_i.dtr};
        end
    end
    // a slow modem answers lag_i plus one cycles late
    assign modem_in_n_o = '{dcd: dcd_n_i, ri: ring_n_i, dsr: dtr_hist_reg[lag_i], cts: rts_hist_reg[lag_i]};
endmodule : umc_modem_model
